/* File: common/ureg_pkg.sv */
// Package with register offsets, field positions and reset values.
package ureg_pkg;
  // Byte offsets of the registers within the register window.
  localparam logic [12:0] OFF_DATA = 13'h1000;
  localparam logic [12:0] OFF_IRQ_ENABLE = 13'h1004;
  localparam logic [12:0] OFF_IRQ_IDENTIFY = 13'h1008;
  localparam logic [12:0] OFF_LINE_CONTROL = 13'h100c;
  localparam logic [12:0] OFF_MODEM_CONTROL = 13'h1010;
  // Address width of the register window.
  localparam int ADDR_W = 13;
  // Reset values.
  localparam logic [7:0] RX_BUFFER_RST = 8'h00;
  localparam logic [7:0] TX_HOLDING_RST = 8'hff;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  // Interrupt enable bit positions.
  localparam int IE_RX_AVAIL = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE_STATUS = 2;
  localparam int IE_MODEM_STATUS = 3;
  localparam int IE_USED_W = 4;
  // Line control bit positions.
  localparam int LC_LEN_LO = 0;
  localparam int LC_LEN_HI = 1;
  localparam int LC_STOP = 2;
  localparam int LC_PARITY_ON = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_STICK = 5;
  localparam int LC_BREAK = 6;
  localparam int LC_DIVISOR = 7;
  // Modem control bit positions.
  localparam int MC_USER_OUTPUT_TWO = 3;
  localparam int MC_LOOP = 4;
  // Interrupt source codes for bits 3..1 of the identify register.
  localparam logic [2:0] ID_LINE_STATUS = 3'h3;
  localparam logic [2:0] ID_RX_AVAIL = 3'h2;
  localparam logic [2:0] ID_TIMEOUT = 3'h6;
  localparam logic [2:0] ID_TX_EMPTY = 3'h1;
  localparam logic [2:0] ID_MODEM = 3'h0;
  // Character length codes.
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h3;
  // Upper nibble of the identify register, always zero.
  localparam logic [3:0] ID_UPPER = 4'h0;
endpackage

/* File: rtl/ureg_irq_prio.sv */
// Prioritised interrupt source encoder for the identify register.
`timescale 1ns/100ps
module ureg_irq_prio
  import ureg_pkg::*;
(
  input wire logic [IE_USED_W-1:0] irq_en,
  input wire logic line_status_evt,
  input wire logic rx_avail_evt,
  input wire logic timeout_evt,
  input wire logic tx_empty_evt,
  input wire logic modem_status_evt,
  output logic irq_pending_n,
  output logic [2:0] irq_source_code
);
  // Each source is gated by its enable bit before it can compete.
  wire ls_act = line_status_evt && irq_en[IE_LINE_STATUS];
  wire rx_act = rx_avail_evt && irq_en[IE_RX_AVAIL];
  // The timeout only ever arises with receive data, so it shares that gate.
  wire to_act = timeout_evt && irq_en[IE_RX_AVAIL];
  wire tx_act = tx_empty_evt && irq_en[IE_TX_EMPTY];
  wire ms_act = modem_status_evt && irq_en[IE_MODEM_STATUS];

  // Pending flag is active low.
  assign irq_pending_n = !(ls_act || rx_act || to_act || tx_act || ms_act);

  // Highest priority wins; zero code when nothing pends.
  always_comb
  begin
    if (ls_act)
      irq_source_code = ID_LINE_STATUS;
    else if (rx_act)
      irq_source_code = ID_RX_AVAIL;
    else if (to_act)
      irq_source_code = ID_TIMEOUT;
    else if (tx_act)
      irq_source_code = ID_TX_EMPTY;
    else
      irq_source_code = ID_MODEM;
  end
endmodule

/* File: rtl/ureg_top.sv */
// Software-visible register logic of a 16450-style UART.
`timescale 1ns/100ps
//
// Contract
// - Read-only receive buffer, resets to zero.
// - Write-only transmit holding, resets to ones.
// - Enable bit 3 gates modem status.
// - Enable bit 2 gates line status.
// - Enable bit 1 gates transmit empty.
// - Enable bit 0 gates receive data.
// - Enable bits 7..4 read zero.
// - Identify bits 7..4 read zero.
// - Identify bit 0 is low-active pending.
// - Source code follows fixed priority.
// - Timeout code ranks third, below receive data.
// - Code valid only while pending; resets zero.
// - Divisor access bit redirects low addresses.
// - Break bit forces serial output low.
// - Stick parity fixes parity bit value.
// - Bit 4 selects even parity.
// - Bit 3 enables parity.
// - Bit 2 selects stop bit count.
// - Bits 1..0 select character length.
// - Modem bit 4 enables loopback.
// - Modem bit 3 drives user output pin.
// - Divisor bytes replace buffer and enable.
module ureg_top
  import ureg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  // Register access port: single-cycle read and write strobes.
  input wire logic [ureg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Receiver side: a character has arrived.
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  // Interrupt source conditions from the line and modem logic.
  input wire logic line_status_evt,
  input wire logic timeout_evt,
  input wire logic tx_empty_evt,
  input wire logic modem_status_evt,
  // Serial data from the transmit shifter, before break gating.
  input wire logic tx_serial,
  // Configuration outputs toward the serialiser and baud generator.
  output logic [7:0] tx_holding,
  output logic tx_holding_load,
  output logic [15:0] divisor,
  output logic [1:0] char_length_sel,
  output logic stop_bits_sel,
  output logic parity_on,
  output logic even_parity_sel,
  output logic stick_parity,
  output logic stick_parity_value,
  output logic loopback_en,
  output logic sout,
  output logic user_out_two_pin_n,
  output logic irq
);
  import ureg_pkg::*;

  // Register state.
  logic [7:0] rx_buffer_q;
  logic [7:0] rx_buffer_d;
  logic rx_full_q; // Receive data waits for software.
  logic rx_full_d;
  logic [7:0] tx_holding_q;
  logic [7:0] tx_holding_d;
  logic [IE_USED_W-1:0] irq_enable_q; // Only the low nibble is kept.
  logic [IE_USED_W-1:0] irq_enable_d;
  logic [7:0] line_control_q;
  logic [7:0] line_control_d;
  logic [7:0] modem_control_q;
  logic [7:0] modem_control_d;
  logic [7:0] divisor_low_q;
  logic [7:0] divisor_low_d;
  logic [7:0] divisor_high_q;
  logic [7:0] divisor_high_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic sout_q;
  logic irq_q;
  logic irq_pending_n;
  logic [2:0] irq_source_code;

  // Address decode; the divisor bit steers the two lowest words.
  wire divisor_access = line_control_q[LC_DIVISOR];
  wire hit_data = (reg_addr == OFF_DATA);
  wire hit_ie = (reg_addr == OFF_IRQ_ENABLE);
  wire hit_id = (reg_addr == OFF_IRQ_IDENTIFY);
  wire hit_lc = (reg_addr == OFF_LINE_CONTROL);
  wire hit_mc = (reg_addr == OFF_MODEM_CONTROL);
  wire sel_buf = hit_data && !divisor_access;
  wire sel_ie = hit_ie && !divisor_access;
  wire sel_dll = hit_data && divisor_access;
  wire sel_dlm = hit_ie && divisor_access;

  // Write strobes.
  wire wr_thr = reg_wr && sel_buf;
  wire wr_ie = reg_wr && sel_ie;
  wire wr_lc = reg_wr && hit_lc;
  wire wr_mc = reg_wr && hit_mc;
  wire wr_dll = reg_wr && sel_dll;
  wire wr_dlm = reg_wr && sel_dlm;
  // Reading the buffer consumes the waiting character.
  wire rd_buf = reg_rd && sel_buf;

  // Identify register image with the zero upper nibble.
  wire [7:0] id_image = {ID_UPPER, irq_source_code, irq_pending_n};
  // Enable register image; bits 7..4 are never stored.
  wire [7:0] ie_image = {{(8 - IE_USED_W){1'b0}}, irq_enable_q};

  // Next-state logic for the storage registers.
  always_comb
  begin
    // Receive: a new arrival overwrites the last character.
    rx_buffer_d = rx_char_valid ? rx_char : rx_buffer_q;
    // Arrival beats a simultaneous read so no character is lost.
    if (rx_char_valid)
      rx_full_d = 1'b1;
    else if (rd_buf)
      rx_full_d = 1'b0;
    else
      rx_full_d = rx_full_q;
    tx_holding_d = wr_thr ? reg_wdata : tx_holding_q;
    irq_enable_d = wr_ie ? reg_wdata[IE_USED_W-1:0] : irq_enable_q;
    line_control_d = wr_lc ? reg_wdata : line_control_q;
    modem_control_d = wr_mc ? reg_wdata : modem_control_q;
    divisor_low_d = wr_dll ? reg_wdata : divisor_low_q;
    divisor_high_d = wr_dlm ? reg_wdata : divisor_high_q;
  end

  // Read data mux; unmapped addresses read zero.
  always_comb
  begin
    if (!reg_rd)
      rdata_d = rdata_q;
    else if (sel_buf)
      rdata_d = rx_buffer_q;
    else if (sel_dll)
      rdata_d = divisor_low_q;
    else if (sel_dlm)
      rdata_d = divisor_high_q;
    else if (sel_ie)
      rdata_d = ie_image;
    else if (hit_id)
      rdata_d = id_image;
    else if (hit_lc)
      rdata_d = line_control_q;
    else if (hit_mc)
      rdata_d = modem_control_q;
    else
      rdata_d = 8'h00;
  end

  // Storage registers, all synchronously reset.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rx_buffer_q <= RX_BUFFER_RST;
      rx_full_q <= 1'b0;
      tx_holding_q <= TX_HOLDING_RST;
      irq_enable_q <= IRQ_ENABLE_RST[IE_USED_W-1:0];
      line_control_q <= LINE_CONTROL_RST;
      modem_control_q <= MODEM_CONTROL_RST;
      divisor_low_q <= DIVISOR_RST;
      divisor_high_q <= DIVISOR_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      rx_buffer_q <= rx_buffer_d;
      rx_full_q <= rx_full_d;
      tx_holding_q <= tx_holding_d;
      irq_enable_q <= irq_enable_d;
      line_control_q <= line_control_d;
      modem_control_q <= modem_control_d;
      divisor_low_q <= divisor_low_d;
      divisor_high_q <= divisor_high_d;
      rdata_q <= rdata_d;
    end
  end

  // Priority encoder; receive-available comes from the buffer's own flag.
  ureg_irq_prio u_prio (
    .irq_en(irq_enable_q),
    .line_status_evt(line_status_evt),
    .rx_avail_evt(rx_full_q),
    .timeout_evt(timeout_evt),
    .tx_empty_evt(tx_empty_evt),
    .modem_status_evt(modem_status_evt),
    .irq_pending_n(irq_pending_n),
    .irq_source_code(irq_source_code)
  );

  // Serial output and interrupt line are registered to avoid glitches.
  // In loopback the line idles high unless break is set, as the shifter is routed inside.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sout_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else
    begin
      if (line_control_q[LC_BREAK])
        sout_q <= 1'b0;
      else if (modem_control_q[MC_LOOP])
        sout_q <= 1'b1;
      else
        sout_q <= tx_serial;
      irq_q <= !irq_pending_n;
    end
  end

  // Configuration fields toward the serialiser.
  assign char_length_sel = line_control_q[LC_LEN_HI:LC_LEN_LO];
  assign stop_bits_sel = line_control_q[LC_STOP];
  assign parity_on = line_control_q[LC_PARITY_ON];
  assign even_parity_sel = line_control_q[LC_EVEN];
  assign stick_parity = line_control_q[LC_STICK] && parity_on;
  // Stuck parity is 1 for odd sense and 0 for even sense.
  assign stick_parity_value = !even_parity_sel;
  assign loopback_en = modem_control_q[MC_LOOP];
  assign user_out_two_pin_n = !modem_control_q[MC_USER_OUTPUT_TWO];
  assign tx_holding = tx_holding_q;
  // Load pulse tells the shifter a new character was written.
  assign tx_holding_load = wr_thr;
  assign divisor = {divisor_high_q, divisor_low_q};
  assign sout = sout_q;
  assign irq = irq_q;
  assign reg_rdata = rdata_q;
endmodule

/* File: sim/ureg_monitor.sv */
// Port checker for the register block.
`timescale 1ns/100ps
module ureg_monitor
  import ureg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ureg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] tx_holding,
  input wire logic tx_holding_load,
  input wire logic [15:0] divisor,
  input wire logic parity_on,
  input wire logic even_parity_sel,
  input wire logic stick_parity,
  input wire logic stick_parity_value,
  input wire logic sout,
  input wire logic user_out_two_pin_n,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Shadow of the divisor access bit, since the checker sees no registers.
  logic divisor_access_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      divisor_access_q <= 1'b0;
    else if (reg_wr && reg_addr == OFF_LINE_CONTROL)
      divisor_access_q <= reg_wdata[LC_DIVISOR];
  end
  a_stick_value: assert property (
    stick_parity |-> parity_on && stick_parity_value == !even_parity_sel)
    else $error("stick parity value wrong");
  a_load_cause: assert property (
    tx_holding_load |-> reg_wr && reg_addr == OFF_DATA)
    else $error("holding load without write");
  a_load_data: assert property (
    tx_holding_load |=> tx_holding == $past(reg_wdata))
    else $error("holding value not stored");
  a_ident_upper: assert property (
    reg_rd && reg_addr == OFF_IRQ_IDENTIFY |=> reg_rdata[7:4] == ID_UPPER)
    else $error("identify upper nibble not zero");
  a_pend_irq: assert property (
    reg_rd && reg_addr == OFF_IRQ_IDENTIFY |=> reg_rdata[0] == !irq)
    else $error("interrupt output disagrees with pending flag");
  a_enable_upper: assert property (
    reg_rd && reg_addr == OFF_IRQ_ENABLE && !divisor_access_q |=> reg_rdata[7:4] == 0)
    else $error("enable upper nibble not zero");
  a_reset_state: assert property (
    $fell(srst) |-> tx_holding == TX_HOLDING_RST && divisor == 16'h0000
      && sout && !irq && user_out_two_pin_n)
    else $error("outputs wrong after reset");
  a_user_output_two_steady: assert property (
    !(reg_wr && reg_addr == OFF_MODEM_CONTROL) |=> $stable(user_out_two_pin_n))
    else $error("user output moved without a write");
  c_irq: cover property (irq);
  c_load: cover property (tx_holding_load);
  c_stick: cover property (stick_parity);
endmodule
bind ureg_top ureg_monitor mon_u (.clk_sys, .srst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .tx_holding, .tx_holding_load, .divisor,
  .parity_on, .even_parity_sel, .stick_parity, .stick_parity_value, .sout,
  .user_out_two_pin_n, .irq);

/* File: sim/ureg_peer.sv */
// Model of the remote serial peer that delivers received characters.
`timescale 1ns/100ps
module ureg_peer
(
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [7:0] char_in,
  output logic rx_char_valid,
  output logic [7:0] rx_char
);
  // Between pulses the data keeps changing, so stale data never matches.
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
  end
  always @(posedge clk_sys)
  begin
    rx_char_valid <= send;
    rx_char <= send ? char_in : ~rx_char;
  end
endmodule

/* File: sim/ureg_top_tb.sv */
// Self-checking bench for the register block.
`timescale 1ns/100ps
module ureg_top_tb;
  import ureg_pkg::*;
  logic clk_sys, srst, reg_wr, reg_rd, rx_char_valid, line_status_evt;
  logic timeout_evt, tx_empty_evt, modem_status_evt, tx_serial, send;
  logic tx_holding_load, stop_bits_sel, parity_on, even_parity_sel, irq;
  logic stick_parity, stick_parity_value, loopback_en, sout;
  logic user_out_two_pin_n;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_char, tx_holding, char_in, v;
  logic [15:0] divisor;
  logic [1:0] char_length_sel;
  logic [7:0] lcr_tab [4] = '{8'h3f, 8'h2a, 8'h15, 8'h08};
  logic [7:0] gate_tab [4] = '{8'h0c, 8'h02, 8'h06, 8'h00};
  int err_count, comparisons, cycles;
  ureg_top dut_u (.clk_sys, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .rx_char_valid, .rx_char, .line_status_evt, .timeout_evt,
    .tx_empty_evt, .modem_status_evt, .tx_serial, .tx_holding,
    .tx_holding_load, .divisor, .char_length_sel, .stop_bits_sel,
    .parity_on, .even_parity_sel, .stick_parity, .stick_parity_value,
    .loopback_en, .sout, .user_out_two_pin_n, .irq);
  ureg_peer peer_u (.clk_sys, .send, .char_in, .rx_char_valid, .rx_char);
  // Compares one value and counts it.
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One write strobe, raised and dropped on falling edges.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  // One read strobe; the data is registered, so look a cycle later.
  task automatic rdc(input string n, input logic [12:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check(n, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Hang guard: the tests need well under a thousand cycles.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    {srst, reg_wr, reg_rd, send, tx_serial} = 5'b10001;
    {line_status_evt, timeout_evt, tx_empty_evt, modem_status_evt} = 4'h0;
    {reg_addr, reg_wdata, char_in} = '0;
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    rdc("ier", OFF_IRQ_ENABLE, 8'h00);
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h01);
    rdc("lcr", OFF_LINE_CONTROL, 8'h00);
    rdc("mcr", OFF_MODEM_CONTROL, 8'h00);
    rdc("rbr", OFF_DATA, 8'h00);
    check("thr", tx_holding, TX_HOLDING_RST);
    wr(OFF_IRQ_ENABLE, 8'hff);
    rdc("ier", OFF_IRQ_ENABLE, 8'h0f);
    // All sources raised together, then retired in priority order.
    {line_status_evt, timeout_evt, tx_empty_evt, modem_status_evt} = 4'hf;
    char_in = 8'ha5;
    send = 1'b1;
    @(negedge clk_sys);
    send = 1'b0;
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h06);
    check("irq", irq, 1'b1);
    line_status_evt = 1'b0;
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h04);
    wr(OFF_DATA, 8'h3c);
    check("thr", tx_holding, 8'h3c);
    rdc("rbr", OFF_DATA, 8'ha5);
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h0c);
    timeout_evt = 1'b0;
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h02);
    tx_empty_evt = 1'b0;
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h00);
    modem_status_evt = 1'b0;
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h01);
    check("irq", irq, 1'b0);
    // Each enable bit alone lets only its own source through.
    {line_status_evt, timeout_evt, tx_empty_evt, modem_status_evt} = 4'hf;
    wr(OFF_IRQ_ENABLE, 8'h00);
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_IRQ_ENABLE, 8'h01 << i);
      rdc("iir", OFF_IRQ_IDENTIFY, gate_tab[i]);
    end
    wr(OFF_IRQ_IDENTIFY, 8'hff);
    rdc("iir", OFF_IRQ_IDENTIFY, 8'h00);
    rdc("gap", 13'h1020, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = lcr_tab[i];
      wr(OFF_LINE_CONTROL, v);
      check("fmt", {char_length_sel, stop_bits_sel, parity_on, even_parity_sel},
        {v[1:0], v[2], v[3], v[4]});
      check("stk", {stick_parity, stick_parity_value},
        {v[5] & v[3], !v[4]});
      rdc("lcr", OFF_LINE_CONTROL, v);
    end
    // The serial output is registered after the control bit, so wait a cycle.
    wr(OFF_LINE_CONTROL, 8'h40);
    @(negedge clk_sys);
    check("brk", sout, 1'b0);
    wr(OFF_LINE_CONTROL, 8'h80);
    @(negedge clk_sys);
    check("sout", sout, 1'b1);
    wr(OFF_DATA, 8'h34);
    wr(OFF_IRQ_ENABLE, 8'h12);
    check("div", divisor, 16'h1234);
    check("thr", tx_holding, 8'h3c);
    rdc("dll", OFF_DATA, 8'h34);
    rdc("dlm", OFF_IRQ_ENABLE, 8'h12);
    wr(OFF_LINE_CONTROL, 8'h00);
    rdc("rbr", OFF_DATA, 8'ha5);
    wr(OFF_MODEM_CONTROL, 8'h18);
    tx_serial = 1'b0;
    @(negedge clk_sys);
    check("mcr", {loopback_en, user_out_two_pin_n, sout}, 3'b101);
    rdc("mcr", OFF_MODEM_CONTROL, 8'h18);
    wr(OFF_MODEM_CONTROL, 8'h00);
    check("user_output_two", user_out_two_pin_n, 1'b1);
    // Out of loopback the low shifter bit reaches the line again.
    @(negedge clk_sys);
    check("pass", sout, 1'b0);
    close_out();
  end
endmodule
